// *** inc/psr_pkg.sv ***
// Notes on behaviour
// - Answer target address 0x38; 0x70 write, 0x71 read.
// - Acknowledge own address on ninth clock.
// - Change SDA only while SCL is low.
// - Start in on-demand mode after reset.
// - Defer mode change until measurement ends.
// - Ignore commands while mode change pending.
// - On-demand measures only on valid trigger.
// - Periodic mode alternates measure and sleep.
// - Periodic mode repeats last trigger settings.
// - Periodic queue on by default, reads drain it.
// - Queue off: reads return last completed result.
// - Writing AC 77 00 starts one measurement.
// - Every read frame begins with status byte.
// - Status byte readable at any time.
// - Queue off: status, pressure, temperature, MSB first.
// - Status bit 7 shows measurement busy.
// - Status bits 6:5 show current mode.
// - Status bit 4 shows memory check failure.
// - Status bit 3 shows calibrated output.
// - Status bits 2:0 show queue on, full, empty.
// - Done output low at start, high at end.
// - Command E1 plus data sets periodic sleep.
// - Queue words carry the full 24-bit value.
package psr_pkg;

  localparam logic [6:0] DEV_ADDR      = 7'h38;
  localparam int         CLK_HZ        = 20_000_000;
  localparam int         MEAS_TIME_US  = 33_000;
  localparam int         MEAS_CYC_DEF  = MEAS_TIME_US * (CLK_HZ / 1_000_000);
  localparam int         MS_CYC_DEF    = CLK_HZ / 1000;

  localparam logic [7:0] CMD_MEAS      = 8'hac;
  localparam logic [7:0] CMD_ON_DEMAND = 8'ha8;
  localparam logic [7:0] CMD_PERIODIC  = 8'he0;
  localparam logic [7:0] CMD_FACTORY   = 8'ha0;
  localparam logic [7:0] CMD_CONFIG    = 8'he1;
  localparam logic [7:0] CMD_SOFT_RST  = 8'hba;
  localparam logic [7:0] CMD_QUEUE_RST = 8'hbb;

  localparam logic [1:0] MODE_OD       = 2'h0;
  localparam logic [1:0] MODE_PER      = 2'h1;
  localparam logic [1:0] MODE_FAC      = 2'h2;

  localparam int         CFG_QUEUE_BIT = 12;
  localparam int         CFG_CAL_BIT   = 11;
  localparam int         CFG_PER_LSB   = 3;
  localparam logic [15:0] CFG_RST      = 16'h1000;
  localparam logic [7:0] OSR_RST       = 8'h77;

  localparam logic [2:0] RD_LAST       = 3'h6;
  localparam logic [2:0] RD_QLAST      = 3'h3;
  localparam int         PERIOD_MS [8] = '{5, 10, 20, 40, 80, 250, 500, 1000};

  typedef struct packed {
    logic       busy;
    logic [1:0] mode;
    logic       crc_fail;
    logic       cal_en;
    logic       queue_en;
    logic       full;
    logic       empty;
  } psr_status_t;

  typedef struct packed {
    logic [23:0] pres;
    logic [23:0] temp;
  } psr_sample_t;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_RX,
    BUS_ACK,
    BUS_TX,
    BUS_TXACK
  } psr_bus_t;

endpackage

// *** core/psr_readout.sv ***
`timescale 1ns/1ps
module psr_readout
  import psr_pkg::*;
#(
  parameter int MEAS_CYC = MEAS_CYC_DEF,
  parameter int MS_CYC   = MS_CYC_DEF,
  parameter int DEPTH    = 8
) (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Two-wire link pins.
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  // Measurement done pin.
  output logic             done_out,
  // Converter and memory check.
  input  wire psr_sample_t sample_in,
  input  wire logic        crc_fail_in
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk_depth
    $error("DEPTH must be a power of two of at least 2.");
  end
  if (MEAS_CYC < 1 || MS_CYC < 1) begin : g_chk_time
    $error("Timing counts must be at least 1.");
  end

  typedef struct packed {
    logic                   scl1;
    logic                   scl2;
    logic                   scl3;
    logic                   sda1;
    logic                   sda2;
    logic                   sda3;
    psr_bus_t               bus;
    logic [3:0]             cnt;
    logic [7:0]             sh;
    logic                   first;
    logic                   rd;
    logic                   drv;
    logic [2:0]             widx;
    logic [7:0]             b0;
    logic [7:0]             b1;
    logic [7:0]             b2;
    logic [2:0]             ridx;
    logic                   data_rd;
    logic [1:0]             mode;
    logic [15:0]            cfg;
    logic [7:0]             osr;
    logic                   busy;
    logic [31:0]            tmr;
    logic                   done;
    logic                   pend;
    logic [1:0]             pmode;
    psr_sample_t            res;
    logic                   push_t;
    logic [DEPTH-1:0][23:0] mem;
    logic [AW:0]            wp;
    logic [AW:0]            rp;
  } psr_state_t;

  psr_state_t q;
  psr_state_t s;

  always_comb begin
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        q_on;
    logic        full;
    logic        empty;
    logic [2:0]  nidx;
    logic [2:0]  k;
    logic [23:0] w;
    logic [7:0]  txb;
    logic [1:0]  nmode;
    logic        go;
    psr_status_t st;
    st    = '0;
    rise  = q.scl2 & ~q.scl3;
    fall  = ~q.scl2 & q.scl3;
    start = q.scl2 & q.scl3 & ~q.sda2 & q.sda3;
    stop  = q.scl2 & q.scl3 & q.sda2 & ~q.sda3;
    q_on  = (q.mode == MODE_PER) && q.cfg[CFG_QUEUE_BIT];
    full  = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
    empty = (q.wp == q.rp);
    nidx  = 3'h0;
    k     = 3'h0;
    w     = 24'h0;
    txb   = 8'h00;
    nmode = q.mode;
    go    = 1'b0;
    s     = q;
    // Two-stage synchronisers for both pins.
    s.scl1 = scl_in;
    s.scl2 = q.scl1;
    s.scl3 = q.scl2;
    s.sda1 = sda_in;
    s.sda2 = q.sda1;
    s.sda3 = q.sda2;

    st.busy     = q.busy;
    st.mode     = q.mode;
    st.crc_fail = crc_fail_in;
    st.cal_en   = q.cfg[CFG_CAL_BIT];
    st.queue_en = q.cfg[CFG_QUEUE_BIT];
    st.full     = full;
    st.empty    = empty;

    // Choose the index of the byte sent next.
    if (q.bus == BUS_TXACK) begin
      if (q_on) begin
        nidx = (q.ridx == RD_QLAST) ? 3'h1 : q.ridx + 3'h1;
      end else begin
        nidx = (q.ridx == 3'h7) ? q.ridx : q.ridx + 3'h1;
      end
    end
    if (q_on) begin
      w = q.mem[q.rp[AW-1:0]];
      k = nidx;
    end else if (nidx <= RD_QLAST) begin
      w = q.res.pres;
      k = nidx;
    end else begin
      w = q.res.temp;
      k = nidx - RD_QLAST;
    end
    if (nidx == 3'h0) begin
      txb = st;
    end else if (nidx > RD_LAST) begin
      txb = 8'h00;
    end else if (k == 3'h1) begin
      txb = w[23:16];
    end else if (k == 3'h2) begin
      txb = w[15:8];
    end else begin
      txb = w[7:0];
    end

    // Measurement timing and periodic sleep.
    if (q.push_t) begin
      s.push_t = 1'b0;
      if (!full) begin
        s.mem[q.wp[AW-1:0]] = q.res.temp;
        s.wp = q.wp + 1'b1;
      end
    end
    if (q.busy) begin
      s.tmr = q.tmr - 32'h1;
      if (q.tmr == 32'h0) begin
        s.busy = 1'b0;
        s.done = 1'b1;
        s.res  = sample_in;
        if (q_on) begin
          if (!full) begin
            s.mem[q.wp[AW-1:0]] = sample_in.pres;
            s.wp = q.wp + 1'b1;
          end
          s.push_t = 1'b1;
        end
        if (q.pend) begin
          s.mode = q.pmode;
          s.pend = 1'b0;
        end
        s.tmr = 32'(PERIOD_MS[q.cfg[CFG_PER_LSB +: 3]] * MS_CYC);
      end
    end else if (q.mode == MODE_PER) begin
      if (q.tmr == 32'h0) begin
        go = 1'b1;
      end else begin
        s.tmr = q.tmr - 32'h1;
      end
    end

    // Two-wire target engine.
    if (start) begin
      s.bus     = BUS_RX;
      s.cnt     = 4'h0;
      s.first   = 1'b1;
      s.drv     = 1'b0;
      s.rd      = 1'b0;
      s.widx    = 3'h0;
      s.data_rd = 1'b0;
    end else if (stop) begin
      s.bus = BUS_IDLE;
      s.drv = 1'b0;
      // done falls after data read.
      // A measurement that ends in this same cycle keeps done set.
      if (q.rd && q.data_rd && q.done) begin
        s.done = 1'b0;
      end
      if (!q.rd && q.widx != 3'h0 && !s.pend) begin
        if (q.b0 == CMD_MEAS && q.widx == 3'h3) begin
          s.osr = q.b1;
          if (q.mode == MODE_OD && !s.busy) begin
            go = 1'b1;
          end
        end else if (q.b0 == CMD_ON_DEMAND || q.b0 == CMD_PERIODIC ||
                     q.b0 == CMD_FACTORY) begin
          nmode = (q.b0 == CMD_ON_DEMAND) ? MODE_OD :
                  (q.b0 == CMD_PERIODIC) ? MODE_PER : MODE_FAC;
          if (s.busy) begin
            s.pend  = 1'b1;
            s.pmode = nmode;
          end else begin
            s.mode = nmode;
            s.tmr  = 32'h0;
          end
        end else if (q.b0 == CMD_CONFIG && q.widx == 3'h3) begin
          s.cfg = {q.b1, q.b2};
        end else if (q.b0 == CMD_SOFT_RST) begin
          s.mode = MODE_OD;
          s.cfg  = CFG_RST;
          s.osr  = OSR_RST;
          s.busy = 1'b0;
          s.done = 1'b0;
          s.tmr  = 32'h0;
          s.wp   = '0;
          s.rp   = '0;
          s.push_t = 1'b0;
        end else if (q.b0 == CMD_QUEUE_RST) begin
          s.rp     = s.wp;
          s.push_t = 1'b0;
        end
      end
    end else begin
      case (q.bus)
        BUS_RX: begin
          if (rise) begin
            s.sh  = {q.sh[6:0], q.sda2};
            s.cnt = q.cnt + 4'h1;
          end
          if (fall && q.cnt == 4'h8) begin
            if (q.first) begin
              if (q.sh[7:1] == DEV_ADDR) begin
                s.rd    = q.sh[0];
                s.first = 1'b0;
                s.bus   = BUS_ACK;
                s.drv   = 1'b1;
              end else begin
                s.bus = BUS_IDLE;
              end
            end else begin
              if (q.widx == 3'h0) begin
                s.b0 = q.sh;
              end else if (q.widx == 3'h1) begin
                s.b1 = q.sh;
              end else if (q.widx == 3'h2) begin
                s.b2 = q.sh;
              end
              s.widx = (q.widx == 3'h7) ? q.widx : q.widx + 3'h1;
              s.bus  = BUS_ACK;
              s.drv  = 1'b1;
            end
          end
        end
        BUS_ACK: begin
          // release or drive after falling clock.
          if (fall) begin
            s.cnt = 4'h0;
            if (q.rd) begin
              s.bus  = BUS_TX;
              s.sh   = txb;
              s.drv  = ~txb[7];
              s.ridx = 3'h0;
            end else begin
              s.bus = BUS_RX;
              s.drv = 1'b0;
            end
          end
        end
        BUS_TX: begin
          if (fall) begin
            if (q.cnt == 4'h7) begin
              s.drv = 1'b0;
              s.bus = BUS_TXACK;
            end else begin
              s.sh  = {q.sh[6:0], 1'b0};
              s.drv = ~q.sh[6];
              s.cnt = q.cnt + 4'h1;
            end
          end
        end
        BUS_TXACK: begin
          if (rise) begin
            if (q.ridx != 3'h0) begin
              s.data_rd = 1'b1;
            end
            if (q_on && q.ridx == RD_QLAST && !empty) begin
              s.rp = q.rp + 1'b1;
            end
            if (q.sda2) begin
              s.bus = BUS_IDLE;
            end
          end else if (fall) begin
            s.bus  = BUS_TX;
            s.cnt  = 4'h0;
            s.ridx = nidx;
            s.sh   = txb;
            s.drv  = ~txb[7];
          end
        end
        default: begin
          s.drv = 1'b0;
        end
      endcase
    end

    if (go) begin
      s.busy = 1'b1;
      s.tmr  = 32'(MEAS_CYC - 1);
      s.done = 1'b0;
    end

    if (rst_in) begin
      s      = '0;
      s.scl1 = 1'b1;
      s.scl2 = 1'b1;
      s.scl3 = 1'b1;
      s.sda1 = 1'b1;
      s.sda2 = 1'b1;
      s.sda3 = 1'b1;
      s.bus  = BUS_IDLE;
      s.mode = MODE_OD;
      s.cfg  = CFG_RST;
      s.osr  = OSR_RST;
    end
  end

  always_ff @(posedge clk_in) begin
    q <= s;
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~q.drv;
  assign done_out     = q.done;

endmodule // psr_readout

// *** sim/psr_readout_checker.sv ***
`timescale 1ns/1ps
module psr_readout_checker
  import psr_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n_out,
  input wire logic        done_out,
  input wire psr_sample_t sample_in,
  input wire logic        crc_fail_in
);
  logic       scl_q;
  logic [4:0] quiet_q;
  // Counts cycles since the clock pin last moved.
  always_ff @(posedge clk_in) begin
    scl_q <= scl_in;
    if (rst_in || scl_in != scl_q) quiet_q <= 5'h0;
    else if (quiet_q != 5'h1f) quiet_q <= quiet_q + 5'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_sda_zero; sda_out == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero)
    else $error("data value not zero");
  property p_rst_oe; $fell(rst_in) |-> sda_oe_n_out; endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("data driven after reset");
  property p_rst_done; $fell(rst_in) |-> !done_out[*4]; endproperty
  a_rst_done: assert property (p_rst_done)
    else $error("done high after reset");
  property p_oe_low; $changed(sda_oe_n_out) |-> !$past(scl_in, 2); endproperty
  a_oe_low: assert property (p_oe_low)
    else $error("data changed while clock high");
  property p_oe_hold;
    (!sda_oe_n_out && $rose(scl_in)) |-> !sda_oe_n_out[*3];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("driven bit not held");
  property p_oe_quiet; !sda_oe_n_out |-> quiet_q < 5'h10; endproperty
  a_oe_quiet: assert property (p_oe_quiet)
    else $error("data driven on idle bus");
  property p_done_rise; $rose(done_out) |-> !$past(done_out, 8); endproperty
  a_done_rise: assert property (p_done_rise)
    else $error("done rose too soon");
  property p_done_fall; $fell(done_out) |=> !done_out[*8]; endproperty
  a_done_fall: assert property (p_done_fall)
    else $error("done low too short");
  c_ack: cover property ($fell(sda_oe_n_out));
  c_done: cover property ($rose(done_out));
  c_drop: cover property ($fell(done_out));
endmodule // psr_readout_checker

bind psr_readout psr_readout_checker chk (
  .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .done_out(done_out),
  .sample_in(sample_in), .crc_fail_in(crc_fail_in));

// *** sim/psr_i2c_host.sv ***
`timescale 1ns/1ps
module psr_i2c_host (
  // Bus pins.
  output logic      scl_out,
  output logic      sda_oe_n_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #150 sda_oe_n_out = b;
    #100 scl_out = 1'b1;
    #100 r = sda_in;
    #50 scl_out = 1'b0;
  endtask
  task automatic start();
    #100 sda_oe_n_out = 1'b0;
    #100 scl_out = 1'b0;
  endtask
  task automatic stop();
    #100 sda_oe_n_out = 1'b0;
    #150 scl_out = 1'b1;
    #150 sda_oe_n_out = 1'b1;
    #200;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // psr_i2c_host

// *** sim/psr_readout_tb_top.sv ***
`timescale 1ns/1ps
module psr_readout_tb_top;
  import psr_pkg::*;
  localparam int          MEAS  = 2000;
  localparam logic [47:0] SMP_A = 48'h123456abcdef;
  localparam logic [47:0] SMP_B = 48'hfedcba987654;
  logic        clk_in;
  logic        rst_in;
  logic        scl;
  logic        sda;
  logic        sda_out;
  logic        dut_oe_n;
  logic        host_oe_n;
  logic        done_out;
  logic        crc_fail_in;
  psr_sample_t sample_in;
  logic [7:0]  rb [7];
  int          num_errors;
  int          tests_run;
  // Open-drain data wire with pull-up.
  assign sda = (!host_oe_n || (!dut_oe_n && !sda_out)) ? 1'b0 : 1'b1;
  psr_readout #(.MEAS_CYC(MEAS), .MS_CYC(10), .DEPTH(8)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(dut_oe_n), .done_out(done_out),
    .sample_in(sample_in), .crc_fail_in(crc_fail_in));
  psr_i2c_host host (.scl_out(scl), .sda_oe_n_out(host_oe_n), .sda_in(sda));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr_cmd(input logic [23:0] c, input int n);
    logic ack;
    @(posedge clk_in);
    #1;
    host.start();
    host.wr_byte(8'h70, ack);
    check("addr ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      host.wr_byte(c[23-8*i -: 8], ack);
      check("data ack", {7'h0, ack}, 8'h01);
    end
    host.stop();
  endtask
  task automatic rd_frame(input int n);
    logic ack;
    @(posedge clk_in);
    #1;
    host.start();
    host.wr_byte(8'h71, ack);
    check("read ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) host.rd_byte(i == n - 1, rb[i]);
    host.stop();
  endtask
  task automatic chk_data(input logic [47:0] e);
    for (int i = 0; i < 6; i++) check("data", rb[i+1], e[47-8*i -: 8]);
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    while (done_out !== 1'b1 && k < 4000) begin
      @(posedge clk_in);
      #1;
      k++;
    end
    check("done", {7'h0, done_out}, 8'h01);
    if (done_out !== 1'b1) give_verdict();
  endtask
  task automatic t_status();
    rd_frame(1);
    check("status", rb[0], 8'h05);
    @(posedge clk_in);
    #1 crc_fail_in = 1'b1;
    rd_frame(1);
    check("crc", rb[0], 8'h15);
    #1 crc_fail_in = 1'b0;
  endtask
  task automatic t_wrong_addr();
    logic ack;
    @(posedge clk_in);
    #1;
    host.start();
    host.wr_byte(8'h72, ack);
    check("other addr", {7'h0, ack}, 8'h00);
    host.stop();
  endtask
  task automatic t_on_demand();
    wr_cmd(24'hac7700, 2);
    rd_frame(1);
    check("short trig", rb[0] & 8'h80, 8'h00);
    wr_cmd(24'hac7700, 3);
    rd_frame(1);
    check("busy", rb[0] & 8'he0, 8'h80);
    wait_done();
    sample_in = SMP_B;
    wr_cmd(24'hac7700, 3);
    check("done start", {7'h0, done_out}, 8'h00);
    rd_frame(7);
    check("busy read", rb[0] & 8'he0, 8'h80);
    chk_data(SMP_A);
    wait_done();
    rd_frame(7);
    check("idle", rb[0] & 8'he0, 8'h00);
    chk_data(SMP_B);
    repeat (4) @(posedge clk_in);
    #1;
    check("done read", {7'h0, done_out}, 8'h00);
  endtask
  task automatic t_defer();
    wr_cmd(24'hac7700, 3);
    wr_cmd(24'he00000, 1);
    wr_cmd(24'ha80000, 1);
    rd_frame(1);
    check("deferred", rb[0] & 8'he0, 8'h80);
    repeat (MEAS) @(posedge clk_in);
    rd_frame(1);
    check("mode", rb[0] & 8'h60, 8'h20);
  endtask
  task automatic t_queue();
    repeat (MEAS + 100) @(posedge clk_in);
    rd_frame(7);
    check("queue", rb[0] & 8'h65, 8'h24);
    chk_data(SMP_B);
  endtask
  task automatic t_cal();
    wr_cmd(24'he10800, 3);
    rd_frame(7);
    check("cal", rb[0] & 8'h6c, 8'h28);
    chk_data(SMP_B);
  endtask
  task automatic t_cmds();
    wr_cmd(24'he11000, 3);
    repeat (MEAS + 100) @(posedge clk_in);
    wr_cmd(24'ha80000, 1);
    repeat (MEAS) @(posedge clk_in);
    rd_frame(1);
    check("held", rb[0] & 8'h61, 8'h00);
    wr_cmd(24'hbb0000, 1);
    rd_frame(1);
    check("flushed", rb[0] & 8'h01, 8'h01);
    wr_cmd(24'ha00000, 1);
    rd_frame(1);
    check("factory", rb[0] & 8'h60, 8'h40);
    wr_cmd(24'hba0000, 1);
    rd_frame(1);
    check("soft reset", rb[0], 8'h05);
  endtask
  initial begin
    num_errors = 0;
    tests_run = 0;
    rst_in = 1'b1;
    crc_fail_in = 1'b0;
    sample_in = SMP_A;
    repeat (4) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    t_status();
    t_wrong_addr();
    t_on_demand();
    t_defer();
    t_queue();
    t_cal();
    t_cmds();
    give_verdict();
  end
endmodule // psr_readout_tb_top
